// [rtl/esl_pkg.sv]
`default_nettype none
package esl_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 10;
    localparam int TICK_MS          = 50;
    localparam int TICK_CYCLES      = TICK_MS * 1000000 / CLK_PERIOD_NS;
    localparam int FAST_PERIOD_MS   = 200;
    localparam int NORMAL_PERIOD_MS = 500;
    localparam int SLOW_ON_MS       = 1000;
    localparam int SLOW_OFF_MS      = 3000;
    localparam logic [6:0] FAST_HALF_TICKS   = 7'(FAST_PERIOD_MS / TICK_MS / 2);
    localparam logic [6:0] NORMAL_HALF_TICKS = 7'(NORMAL_PERIOD_MS / TICK_MS / 2);
    localparam logic [6:0] SLOW_ON_TICKS     = 7'(SLOW_ON_MS / TICK_MS);
    localparam logic [6:0] SLOW_OFF_TICKS    = 7'(SLOW_OFF_MS / TICK_MS);

    // ------------------------------------------------------------
    // fault sources and codes
    // ------------------------------------------------------------
    localparam int NUM_CHAN      = 6;
    localparam int NUM_SRC       = 14;
    localparam int SRC_HW_ERR    = 0;
    localparam int SRC_VOLT_ERR  = 1;
    localparam int SRC_VOLT_WARN = 2;
    localparam int SRC_HW_WARN   = 3;
    localparam int SRC_CJC_WARN  = 4;
    localparam int SRC_CH1       = 5;
    localparam int SRC_PROG      = 11;
    localparam int SRC_SERIOUS   = 12;
    localparam int SRC_WARN      = 13;

    localparam logic [15:0] CODE_HW_ERR    = 16'h1605;
    localparam logic [15:0] CODE_VOLT_ERR  = 16'h1607;
    localparam logic [15:0] CODE_VOLT_WARN = 16'h1801;
    localparam logic [15:0] CODE_HW_WARN   = 16'h1802;
    localparam logic [15:0] CODE_CJC_WARN  = 16'h1807;
    localparam logic [15:0] CODE_CH1       = 16'h1808;
    localparam logic [15:0] CODE_NONE      = 16'h0000;

    localparam logic [6:0]  PHASE_RST = 7'h00;

    typedef enum logic [2:0] {
        ESL_SEV_OFF,
        ESL_SEV_SLOW,
        ESL_SEV_NORMAL,
        ESL_SEV_FAST,
        ESL_SEV_ON
    } esl_sev_e;

    typedef struct packed {
        logic                   hwErr;
        logic                   voltErr;
        logic                   voltWarn;
        logic                   hwWarn;
        logic                   cjcWarn;
        logic [NUM_CHAN-1:0]    chanOver;
        logic                   progErr;
        logic                   seriousErr;
        logic                   genWarn;
    } esl_fault_s;

    typedef struct packed {
        logic                   downgrade;
        logic                   escalate;
        logic                   warnSilent;
        logic                   userActEn;
        logic                   userActStop;
    } esl_opt_s;

    typedef struct packed {
        logic [15:0]            code;
        logic                   strobe;
        logic                   isError;
    } esl_report_s;

    typedef struct packed {
        logic [31:0]            count;
        logic                   tick;
    } esl_tb_s;

    typedef struct packed {
        esl_sev_e               sev;
        logic [6:0]             phase;
        logic                   ledOn;
        logic                   runStop;
        logic [NUM_SRC-1:0]     prevSrc;
        esl_report_s            rep;
    } esl_state_s;

endpackage
`default_nettype wire

// [rtl/esl_timebase.sv]
`timescale 1ns/10ps
`default_nettype none
module esl_timebase #(
    parameter int TICK_CYCLES = esl_pkg::TICK_CYCLES
) (
    input  wire logic clk,
    input  wire logic srst,
    output logic      tick
);
    import esl_pkg::*;

    esl_tb_s tb_r;
    esl_tb_s tb_nxt;

    // free-running; one pulse every TICK_CYCLES clocks
    always_comb begin
        tb_nxt = tb_r;
        tb_nxt.tick = 1'b0;
        if (tb_r.count == 32'(TICK_CYCLES - 1)) begin
            tb_nxt.count = 32'h0000_0000;
            tb_nxt.tick  = 1'b1;
        end else begin
            tb_nxt.count = tb_r.count + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            tb_r <= '0;
        end else begin
            tb_r <= tb_nxt;
        end
    end

    assign tick = tb_r.tick;

    tick_period_a: assert property (@(posedge clk) disable iff (srst)
        tick |=> !tick) else $error("timebase tick longer than one cycle");
endmodule
`default_nettype wire

// [rtl/error_status_led.sv]
`timescale 1ns/10ps
`default_nettype none
// Function
// - serious error: indicator steadily lit
// - power or hardware warning: fast blink
// - program error: normal blink
// - warning: lit 1 s, dark 3 s
// - silent warning: dark, keep running
// - codes 1605/1607 are error class, lit
// - downgrade option turns those into warnings
// - 1801/1802/1807 warn, fast blink, running
// - channel over-range codes 1808 to 180D
// - escalation stops on first four warnings
// - each new occurrence reports a readable code; of simultaneous ones, only the lowest index
// - run action per code class: stop on error, continue on warning; one user status overrides all codes
module error_status_led #(
    parameter int          TICK_CYCLES = esl_pkg::TICK_CYCLES,
    parameter logic [15:0] CODE_PROG   = 16'h0100,
    parameter logic [15:0] CODE_SERIOUS = 16'h0200,
    parameter logic [15:0] CODE_WARN   = 16'h0300
) (
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire esl_pkg::esl_fault_s fault,
    input  wire esl_pkg::esl_opt_s   opt,
    output logic                     ledOn,
    output logic                     runStop,
    output esl_pkg::esl_sev_e        severity,
    output esl_pkg::esl_report_s     report
);
    import esl_pkg::*;

    // ------------------------------------------------------------
    // timebase
    // ------------------------------------------------------------
    logic tick;

    esl_timebase #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timebase (
        .clk  (clk),
        .srst (srst),
        .tick (tick)
    );

    // ------------------------------------------------------------
    // source table
    // ------------------------------------------------------------
    logic [NUM_SRC-1:0] src;
    logic [15:0]        srcCode [NUM_SRC];
    logic [NUM_SRC-1:0] srcIsErr;

    assign src = {fault.genWarn, fault.seriousErr, fault.progErr, fault.chanOver,
                  fault.cjcWarn, fault.hwWarn, fault.voltWarn, fault.voltErr,
                  fault.hwErr};

    assign srcCode[SRC_HW_ERR]    = CODE_HW_ERR;
    assign srcCode[SRC_VOLT_ERR]  = CODE_VOLT_ERR;
    assign srcCode[SRC_VOLT_WARN] = CODE_VOLT_WARN;
    assign srcCode[SRC_HW_WARN]   = CODE_HW_WARN;
    assign srcCode[SRC_CJC_WARN]  = CODE_CJC_WARN;
    assign srcCode[SRC_PROG]      = CODE_PROG;
    assign srcCode[SRC_SERIOUS]   = CODE_SERIOUS;
    assign srcCode[SRC_WARN]      = CODE_WARN;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
            assign srcCode[SRC_CH1+gi] = CODE_CH1 + 16'(gi);
        end
    endgenerate

    // error class per source, after the option bits
    always_comb begin
        srcIsErr = '0;
        srcIsErr[SRC_HW_ERR]    = !opt.downgrade;
        srcIsErr[SRC_VOLT_ERR]  = !opt.downgrade;
        srcIsErr[SRC_VOLT_WARN] = opt.escalate;
        srcIsErr[SRC_HW_WARN]   = opt.escalate;
        srcIsErr[SRC_CJC_WARN]  = opt.escalate;
        srcIsErr[SRC_CH1]       = opt.escalate;
        srcIsErr[SRC_PROG]      = 1'b1;
        srcIsErr[SRC_SERIOUS]   = 1'b1;
    end

    // ------------------------------------------------------------
    // classification and indicator pattern
    // ------------------------------------------------------------
    esl_state_s st_r;
    esl_state_s st_nxt;
    esl_sev_e   sevNow;
    logic [NUM_SRC-1:0] rising;
    logic       sevChange;
    logic       moduleErr;
    logic       fastWarn;

    always_comb begin
        st_nxt    = st_r;
        moduleErr = fault.hwErr | fault.voltErr;
        fastWarn  = fault.voltWarn | fault.hwWarn | fault.cjcWarn | (|fault.chanOver);

        // highest pattern wins when several conditions overlap
        if (fault.seriousErr || (moduleErr && !opt.downgrade)) begin
            sevNow = ESL_SEV_ON;
        end else if (fastWarn) begin
            sevNow = ESL_SEV_FAST;
        end else if (fault.progErr) begin
            sevNow = ESL_SEV_NORMAL;
        end else if (moduleErr || (fault.genWarn && !opt.warnSilent)) begin
            sevNow = ESL_SEV_SLOW;
        end else begin
            sevNow = ESL_SEV_OFF;
        end

        st_nxt.sev = sevNow;
        sevChange  = (sevNow != st_r.sev);
        if (sevChange) begin
            st_nxt.phase = PHASE_RST;
            st_nxt.ledOn = (sevNow != ESL_SEV_OFF);
        end else if (tick) begin
            st_nxt.phase = st_r.phase + 7'h01;
            unique case (st_r.sev)
                ESL_SEV_OFF: begin
                    st_nxt.phase = PHASE_RST;
                    st_nxt.ledOn = 1'b0;
                end
                ESL_SEV_ON: begin
                    st_nxt.phase = PHASE_RST;
                    st_nxt.ledOn = 1'b1;
                end
                ESL_SEV_FAST: begin
                    if (st_r.phase == FAST_HALF_TICKS - 7'h01) begin
                        st_nxt.phase = PHASE_RST;
                        st_nxt.ledOn = !st_r.ledOn;
                    end
                end
                ESL_SEV_NORMAL: begin
                    if (st_r.phase == NORMAL_HALF_TICKS - 7'h01) begin
                        st_nxt.phase = PHASE_RST;
                        st_nxt.ledOn = !st_r.ledOn;
                    end
                end
                ESL_SEV_SLOW: begin
                    if (st_r.ledOn && st_r.phase == SLOW_ON_TICKS - 7'h01) begin
                        st_nxt.phase = PHASE_RST;
                        st_nxt.ledOn = 1'b0;
                    end else if (!st_r.ledOn && st_r.phase == SLOW_OFF_TICKS - 7'h01) begin
                        st_nxt.phase = PHASE_RST;
                        st_nxt.ledOn = 1'b1;
                    end
                end
            endcase
        end

        // run action: user status overrides the class default
        if (opt.userActEn) begin
            st_nxt.runStop = opt.userActStop;
        end else begin
            st_nxt.runStop = |(src & srcIsErr);
        end

        // code report on each new occurrence; only the lowest index when several rise together
        rising = src & ~st_r.prevSrc;
        st_nxt.prevSrc    = src;
        st_nxt.rep.strobe = 1'b0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (rising[i]) begin
                st_nxt.rep.code    = srcCode[i];
                st_nxt.rep.isError = srcIsErr[i];
                st_nxt.rep.strobe  = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r         <= '0;
            st_r.sev     <= ESL_SEV_OFF;
            st_r.rep.code <= CODE_NONE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ledOn    = st_r.ledOn;
    assign runStop  = st_r.runStop;
    assign severity = st_r.sev;
    assign report   = st_r.rep;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    serious_lit_a: assert property (@(posedge clk) disable iff (srst)
        fault.seriousErr [*2] |=> ledOn && severity == ESL_SEV_ON)
        else $error("serious error not steady on");

    fast_toggle_a: assert property (@(posedge clk) disable iff (srst)
        st_r.sev == ESL_SEV_FAST && !sevChange && tick
            && st_r.phase == FAST_HALF_TICKS - 7'h01 |=> ledOn != $past(ledOn))
        else $error("fast blink missed toggle");

    normal_toggle_a: assert property (@(posedge clk) disable iff (srst)
        st_r.sev == ESL_SEV_NORMAL && !sevChange && tick
            && st_r.phase == NORMAL_HALF_TICKS - 7'h01 |=> ledOn != $past(ledOn))
        else $error("normal blink missed toggle");

    slow_dark_a: assert property (@(posedge clk) disable iff (srst)
        st_r.sev == ESL_SEV_SLOW && !sevChange && tick && ledOn
            && st_r.phase == SLOW_ON_TICKS - 7'h01 |=> !ledOn)
        else $error("slow blink stayed lit too long");

    silent_dark_a: assert property (@(posedge clk) disable iff (srst)
        src == NUM_SRC'(1 << SRC_WARN) && opt.warnSilent && !opt.userActEn
            |=> !ledOn && !runStop)
        else $error("silent warning lit indicator");

    downgrade_run_a: assert property (@(posedge clk) disable iff (srst)
        src == NUM_SRC'(1 << SRC_HW_ERR) && opt.downgrade && !opt.userActEn
            |=> !runStop && severity == ESL_SEV_SLOW)
        else $error("downgraded error still stops");

    escalate_stop_a: assert property (@(posedge clk) disable iff (srst)
        fault.voltWarn && opt.escalate && !opt.userActEn |=> runStop)
        else $error("escalated warning did not stop");

    chan_code_a: assert property (@(posedge clk) disable iff (srst)
        src == NUM_SRC'(1 << (SRC_CH1 + 5)) && st_r.prevSrc == '0
            |=> report.strobe && report.code == 16'h180D)
        else $error("channel six code wrong");

    phase_restart_a: assert property (@(posedge clk) disable iff (srst)
        sevChange |=> st_r.phase == PHASE_RST && ledOn == (severity != ESL_SEV_OFF))
        else $error("pattern phase not restarted");
endmodule
`default_nettype wire

// [tb/esl_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// host side: keeps the last reported code
// ----------------------------------------
module esl_host_model (
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire esl_pkg::esl_report_s report,
    input  wire logic                 moduleSeen,
    output logic [15:0]               lastCode,
    output logic                      noModule
);
    import esl_pkg::*;
    always_ff @(posedge clk) begin
        if (srst) begin
            lastCode <= 16'h0000;
        end else if (report.strobe) begin
            lastCode <= report.code;
        end
    end
    // missing module gives a flag only, never a code
    assign noModule = !moduleSeen;
endmodule
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import esl_pkg::*;
    localparam int TC = 4;
    typedef struct {
        int src; logic [4:0] opt; esl_sev_e sev; logic stop; logic [15:0] code; logic err;
    } esl_row_s;
    logic        clk;
    logic        srst;
    logic        moduleSeen;
    esl_fault_s  fault;
    esl_opt_s    opt;
    logic        ledOn;
    logic        runStop;
    esl_sev_e    severity;
    esl_report_s report;
    logic [15:0] lastCode;
    logic        noModule;
    int          n_errors;
    int          n_tests;
    esl_row_s    rows[$];

    error_status_led #(.TICK_CYCLES(TC)) error_status_led_inst (
        .clk(clk), .srst(srst), .fault(fault), .opt(opt), .ledOn(ledOn),
        .runStop(runStop), .severity(severity), .report(report));
    esl_host_model esl_host_model_inst (
        .clk(clk), .srst(srst), .report(report), .moduleSeen(moduleSeen),
        .lastCode(lastCode), .noModule(noModule));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic complete_run;
        if (n_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic cmpVal(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic cmpSev(input esl_sev_e got, input esl_sev_e exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t severity got %0d exp %0d", $time, got, exp);
        end
    endtask

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    task automatic apply(input esl_fault_s f, input logic [4:0] o);
        @(posedge clk);
        fault <= f;
        opt <= esl_opt_s'(o);
        step();
    endtask

    // source index in reporting order, one hot
    function automatic esl_fault_s mk(input int src);
        logic [13:0] v;
        v = 14'h0000;
        v[(src >= 5 && src < 11) ? src - 2 : 13 - src] = 1'b1;
        return esl_fault_s'(v);
    endfunction

    task automatic addRow(input int s, input logic [4:0] o, input esl_sev_e v,
                          input logic st, input logic [15:0] c, input logic e);
        rows.push_back('{s, o, v, st, c, e});
    endtask

    // count cycles of each level after the first toggle
    task automatic blink(input int src, input int lenA, input int lenB);
        int n;
        logic lv;
        apply('0, 5'h00);
        apply(mk(src), 5'h00);
        for (int k = 0; k < 3; k++) begin
            lv = ledOn;
            n = 0;
            while (ledOn === lv && n < 400) begin
                step();
                n++;
            end
            if (n >= 400) begin
                n_errors++;
                complete_run();
            end
            if (k > 0) cmpVal(16'(n), 16'(k == 1 ? lenA : lenB), "half period");
        end
    endtask

    task automatic steady(input int src, input logic [4:0] o, input logic lv);
        int bad;
        bad = 0;
        apply(mk(src), o);
        repeat (300) begin
            step();
            if (ledOn !== lv) bad++;
        end
        cmpVal(16'(bad), 16'h0000, "steady level");
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int n;
        srst = 1'b1;
        moduleSeen = 1'b0;
        fault = '0;
        opt = '0;
        n_errors = 0;
        n_tests = 0;
        step();
        cmpVal(16'(noModule), 16'h0001, "no module flag");
        cmpVal(lastCode, 16'h0000, "no module code");
        @(posedge clk);
        srst <= 1'b0;
        moduleSeen <= 1'b1;
        step();
        cmpVal(16'(noModule), 16'h0000, "module seen");
        cmpVal(16'(ledOn), 16'h0000, "reset led");
        cmpVal(16'(runStop), 16'h0000, "reset stop");
        cmpSev(severity, ESL_SEV_OFF);
        cmpVal(report.code, 16'h0000, "reset code");
        cmpVal(16'(report.strobe), 16'h0000, "reset strobe");

        addRow(0, 5'h00, ESL_SEV_ON, 1'b1, 16'h1605, 1'b1);
        addRow(1, 5'h00, ESL_SEV_ON, 1'b1, 16'h1607, 1'b1);
        addRow(0, 5'h10, ESL_SEV_SLOW, 1'b0, 16'h1605, 1'b0);
        addRow(1, 5'h10, ESL_SEV_SLOW, 1'b0, 16'h1607, 1'b0);
        addRow(2, 5'h00, ESL_SEV_FAST, 1'b0, 16'h1801, 1'b0);
        addRow(3, 5'h00, ESL_SEV_FAST, 1'b0, 16'h1802, 1'b0);
        addRow(4, 5'h00, ESL_SEV_FAST, 1'b0, 16'h1807, 1'b0);
        addRow(2, 5'h08, ESL_SEV_FAST, 1'b1, 16'h1801, 1'b1);
        addRow(3, 5'h08, ESL_SEV_FAST, 1'b1, 16'h1802, 1'b1);
        addRow(4, 5'h08, ESL_SEV_FAST, 1'b1, 16'h1807, 1'b1);
        for (int c = 0; c < 6; c++) begin
            addRow(5 + c, 5'h00, ESL_SEV_FAST, 1'b0, 16'h1808 + 16'(c), 1'b0);
            addRow(5 + c, 5'h08, ESL_SEV_FAST, c == 0, 16'h1808 + 16'(c), c == 0);
        end
        addRow(11, 5'h00, ESL_SEV_NORMAL, 1'b1, 16'h0100, 1'b1);
        addRow(11, 5'h02, ESL_SEV_NORMAL, 1'b0, 16'h0100, 1'b1);
        addRow(12, 5'h00, ESL_SEV_ON, 1'b1, 16'h0200, 1'b1);
        addRow(13, 5'h00, ESL_SEV_SLOW, 1'b0, 16'h0300, 1'b0);
        addRow(13, 5'h04, ESL_SEV_OFF, 1'b0, 16'h0300, 1'b0);
        addRow(13, 5'h03, ESL_SEV_SLOW, 1'b1, 16'h0300, 1'b0);

        foreach (rows[i]) begin
            apply('0, rows[i].opt);
            apply(mk(rows[i].src), rows[i].opt);
            cmpSev(severity, rows[i].sev);
            cmpVal(16'(runStop), 16'(rows[i].stop), "stop");
            cmpVal(report.code, rows[i].code, "code");
            cmpVal(16'(report.isError), 16'(rows[i].err), "class");
            cmpVal(16'(report.strobe), 16'h0001, "strobe");
            cmpVal(16'(ledOn), 16'(rows[i].sev != ESL_SEV_OFF), "led at change");
            step();
            cmpVal(16'(report.strobe), 16'h0000, "strobe width");
            cmpVal(lastCode, rows[i].code, "host code");
        end

        // ----------------------------------------
        // awkward cases
        // ----------------------------------------
        apply('0, 5'h00);
        apply(esl_fault_s'(mk(0) | mk(2)), 5'h00);
        cmpVal(report.code, 16'h1605, "tie code");
        cmpSev(severity, ESL_SEV_ON);
        apply(mk(2), 5'h00);
        cmpSev(severity, ESL_SEV_FAST);
        cmpVal(16'(report.strobe), 16'h0000, "no rereport");

        blink(2, 8, 8);
        blink(11, 20, 20);
        blink(13, 240, 80);
        steady(12, 5'h00, 1'b1);
        steady(13, 5'h04, 1'b0);

        // reset in mid-run with a source held high
        apply(mk(12), 5'h00);
        @(posedge clk);
        srst <= 1'b1;
        step();
        cmpSev(severity, ESL_SEV_OFF);
        cmpVal(16'(ledOn), 16'h0000, "reset led");
        cmpVal(16'(runStop), 16'h0000, "reset stop");
        cmpVal(report.code, 16'h0000, "reset code");
        @(posedge clk);
        srst <= 1'b0;
        n = 0;
        step();
        while (report.strobe !== 1'b1 && n < 5) begin
            step();
            n++;
        end
        if (n >= 5) begin
            n_errors++;
            complete_run();
        end
        cmpVal(16'(n), 16'h0000, "strobe delay");
        cmpVal(report.code, 16'h0200, "code after reset");
        cmpSev(severity, ESL_SEV_ON);
        complete_run();
    end
endmodule
`default_nettype wire
